/* logic/ldcs_bank.sv */
`timescale 1ns/1ps
// configuration and fault status bank behind the serial chain
module ldcs_bank (
  // clock, reset, enable
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic                               ce,
  // serial pins
  input  wire logic                               sclk_pin,
  input  wire logic                               sdi_pin,
  input  wire logic                               latch_pin,
  output logic                                    sdo_pin,
  // fault detectors, {blue, green, red}, bit n is channel n
  input  wire logic [ldcs_pkg::GRP_W-1:0]         open_detect_level_two,
  input  wire logic [ldcs_pkg::GRP_W-1:0]         open_detect_level_one,
  input  wire logic [ldcs_pkg::GRP_W-1:0]         adjacent_pin_short,
  input  wire logic [ldcs_pkg::GRP_W-1:0]         short_detect_level_two,
  input  wire logic [ldcs_pkg::GRP_W-1:0]         short_detect_level_one,
  // single flags and test codes
  input  wire logic                               thermal_error_flag,
  input  wire logic                               overtemp_warning,
  input  wire logic [ldcs_pkg::CODE_W-1:0]        pin_short_test_result,
  input  wire logic                               reference_short_fault,
  input  wire logic                               reference_open_fault,
  input  wire logic [ldcs_pkg::CODE_W-1:0]        open_short_selftest_result,
  // configuration outputs
  output logic                                    red_current_range_sel,
  output logic [ldcs_pkg::BR_W-1:0]               blue_group_brightness,
  output logic [ldcs_pkg::BR_W-1:0]               green_group_brightness,
  output logic [ldcs_pkg::BR_W-1:0]               red_group_brightness,
  output logic [ldcs_pkg::TRIM_ALL_W-1:0]         channel_current_trim,
  // status outputs
  output logic [ldcs_pkg::FRAME_W-1:0]            fault_status_word,
  output logic [1:0]                              loaded_offset
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int SYNC_W = 5 * ldcs_pkg::GRP_W + 4 + 2 * ldcs_pkg::CODE_W;

  logic [2:0]                          pins_s;
  logic [SYNC_W-1:0]                   det_raw;
  logic [SYNC_W-1:0]                   det_s;
  logic                                sclk_s;
  logic                                sdi_s;
  logic                                latch_s;
  logic                                sclk_prev_r;
  logic                                latch_prev_r;
  logic                                sclk_rise;
  logic                                latch_rise;
  ldcs_pkg::ldcs_state_t               state_r;
  ldcs_pkg::ldcs_state_t               state_nxt;
  logic [ldcs_pkg::FRAME_W-1:0]        frame;
  logic [ldcs_pkg::FRAME_W-1:0]        load_val;
  logic                                load_en;
  logic [11:0]                         frame_cmd;
  logic                                apply_stat;
  logic                                apply_cfg;
  logic                                apply_wr;
  logic [ldcs_pkg::CFG_KEEP_W-1:0]     cfg_r;
  logic [11:0]                         cmd_r;
  logic [ldcs_pkg::FRAME_W-1:0]        status_r;
  logic [ldcs_pkg::FRAME_W-1:0]        status_nxt;
  logic [ldcs_pkg::FRAME_W-1:0]        cfg_view;
  logic [1:0]                          offset_r;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // serial pins pass two flops before any logic
  ldcs_sync #(
    .W (3)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({sclk_pin, sdi_pin, latch_pin}),
    .q     (pins_s)
  );

  assign sclk_s  = pins_s[2];
  assign sdi_s   = pins_s[1];
  assign latch_s = pins_s[0];

  // detector levels come from analog circuits on another timebase
  assign det_raw = {open_detect_level_two,
                    open_detect_level_one,
                    adjacent_pin_short,
                    thermal_error_flag,
                    overtemp_warning,
                    pin_short_test_result,
                    reference_short_fault,
                    reference_open_fault,
                    open_short_selftest_result,
                    short_detect_level_two,
                    short_detect_level_one};

  ldcs_sync #(
    .W (SYNC_W)
  ) u_det_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (det_raw),
    .q     (det_s)
  );

  // ****************************************************************
  // edge detection on synchronised serial pins
  // ****************************************************************
  // previous levels for rising-edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev_r  <= 1'b0;
      latch_prev_r <= 1'b0;
    end else if (ce) begin
      sclk_prev_r  <= sclk_s;
      latch_prev_r <= latch_s;
    end
  end

  assign sclk_rise  = ce & sclk_s & ~sclk_prev_r;
  assign latch_rise = ce & latch_s & ~latch_prev_r;

  // ****************************************************************
  // frame state machine
  // ****************************************************************
  // next state: shift until latch, then one apply cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ldcs_pkg::LDCS_IDLE: begin
        if (latch_rise) begin
          state_nxt = ldcs_pkg::LDCS_APPLY;
        end else if (sclk_rise) begin
          state_nxt = ldcs_pkg::LDCS_SHIFT;
        end
      end
      ldcs_pkg::LDCS_SHIFT: begin
        if (latch_rise) begin
          state_nxt = ldcs_pkg::LDCS_APPLY;
        end
      end
      ldcs_pkg::LDCS_APPLY: begin
        state_nxt = ldcs_pkg::LDCS_IDLE;
      end
      default: begin
        state_nxt = ldcs_pkg::LDCS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ldcs_pkg::LDCS_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  // frames from farther devices pass through: each keeps its last 288 bits
  assign frame_cmd  = frame[ldcs_pkg::CMD_HI:ldcs_pkg::CMD_LO];
  assign apply_stat = ce && (state_r == ldcs_pkg::LDCS_APPLY)
                      && (frame_cmd == ldcs_pkg::CMD_READ_STAT);
  assign apply_cfg  = ce && (state_r == ldcs_pkg::LDCS_APPLY)
                      && (frame_cmd == ldcs_pkg::CMD_READ_CFG);
  assign apply_wr   = ce && (state_r == ldcs_pkg::LDCS_APPLY)
                      && !apply_stat && !apply_cfg;

  // ****************************************************************
  // frame shift register
  // ****************************************************************
  // configuration as read back: command, reserved zeros, kept fields
  assign cfg_view = {cmd_r, {ldcs_pkg::CFG_RSV_W{1'b0}}, cfg_r};

  // a read command loads the chosen word for shifting out
  always_comb begin
    load_en  = apply_stat | apply_cfg;
    load_val = apply_stat ? status_r : cfg_view;
  end

  ldcs_shift #(
    .W (ldcs_pkg::FRAME_W)
  ) u_shift (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .shift_en (sclk_rise),
    .sdi_bit  (sdi_s),
    .sdo      (sdo_pin),
    .load_en  (load_en),
    .load_val (load_val),
    .data     (frame)
  );

  // ****************************************************************
  // configuration register
  // ****************************************************************
  // any other command writes the configuration fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= ldcs_pkg::CFG_RESET_VAL;
      cmd_r <= ldcs_pkg::CMD_RESET_VAL;
    end else if (ce && state_r == ldcs_pkg::LDCS_APPLY) begin
      cmd_r <= frame_cmd;
      if (apply_wr) begin
        cfg_r <= frame[ldcs_pkg::CFG_KEEP_W-1:0];
      end
    end
  end

  // field views of the configuration
  assign red_current_range_sel  = cfg_r[ldcs_pkg::POS_RANGE_R];
  assign blue_group_brightness  = cfg_r[ldcs_pkg::BLUE_BR_LO +: ldcs_pkg::BR_W];
  assign green_group_brightness = cfg_r[ldcs_pkg::GREEN_BR_LO +: ldcs_pkg::BR_W];
  assign red_group_brightness   = cfg_r[ldcs_pkg::RED_BR_LO +: ldcs_pkg::BR_W];
  assign channel_current_trim   = cfg_r[ldcs_pkg::TRIM_ALL_W-1:0];

  // ****************************************************************
  // status word
  // ****************************************************************
  // assemble flags at their fixed positions, spare bits zero
  always_comb begin
    status_nxt = ldcs_pkg::STATUS_RESET_VAL;
    status_nxt[ldcs_pkg::OPEN2_LO +: ldcs_pkg::GRP_W]  = det_s[106 +: 24];
    status_nxt[ldcs_pkg::OPEN1_LO +: ldcs_pkg::GRP_W]  = det_s[82 +: 24];
    status_nxt[ldcs_pkg::APS_LO +: ldcs_pkg::GRP_W]    = det_s[58 +: 24];
    status_nxt[ldcs_pkg::POS_THERM]                    = det_s[57];
    status_nxt[ldcs_pkg::POS_WARN]                     = det_s[56];
    status_nxt[ldcs_pkg::PSR_LO +: ldcs_pkg::CODE_W]   = det_s[53 +: 3];
    status_nxt[ldcs_pkg::POS_REF_SHORT]                = det_s[52];
    status_nxt[ldcs_pkg::POS_REF_OPEN]                 = det_s[51];
    status_nxt[ldcs_pkg::STR_LO +: ldcs_pkg::CODE_W]   = det_s[48 +: 3];
    status_nxt[ldcs_pkg::SHORT2_LO +: ldcs_pkg::GRP_W] = det_s[24 +: 24];
    status_nxt[ldcs_pkg::SHORT1_LO +: ldcs_pkg::GRP_W] = det_s[0 +: 24];
  end

  // status follows the detectors, read-only from the serial side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= ldcs_pkg::STATUS_RESET_VAL;
    end else if (ce) begin
      status_r <= status_nxt;
    end
  end

  assign fault_status_word = status_r;

  // ****************************************************************
  // loaded word indicator
  // ****************************************************************
  // shows the offset of the word last placed on the chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offset_r <= 2'h0;
    end else if (apply_stat) begin
      offset_r <= ldcs_pkg::STATUS_OFFSET;
    end else if (apply_cfg) begin
      offset_r <= ldcs_pkg::CFG_OFFSET;
    end
  end

  assign loaded_offset = offset_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_range_write: assert property (
    apply_wr |=> red_current_range_sel == $past(frame[192]))
    else $error("range select not taken from bit 192");

  chk_bright_write: assert property (
    apply_wr |=> blue_group_brightness == $past(frame[191:184])
                 && red_group_brightness == $past(frame[175:168]))
    else $error("group brightness not taken from its field");

  chk_trim_write: assert property (
    apply_wr |=> channel_current_trim[167:161] == $past(frame[167:161])
                 && channel_current_trim[6:0] == $past(frame[6:0]))
    else $error("channel trim not taken from its field");

  chk_status_read: assert property (
    apply_stat |=> frame == $past(status_r) && sdo_pin == $past(status_r[287]))
    else $error("status readout did not load the status word");

  chk_cfg_read: assert property (
    apply_cfg |=> frame[192:0] == $past(cfg_r) && frame[275:193] == '0)
    else $error("configuration readout wrong");

  chk_read_keeps_cfg: assert property (
    (apply_stat || apply_cfg) |=> $stable(cfg_r))
    else $error("a read command changed the configuration");

  chk_status_spare: assert property (
    status_r[143:0] == '0 && status_r[205:192] == '0)
    else $error("reserved status bits not zero");

  chk_thermal_flag: assert property (
    ce && thermal_error_flag ##1 ce ##1 ce |=> status_r[215])
    else $error("thermal error not reported after synchronising");

  chk_open_map: assert property (
    ce |=> status_r[287:264] == $past(det_s[129:106]))
    else $error("open flags out of place");

  chk_apply_once: assert property (
    state_r == ldcs_pkg::LDCS_APPLY && ce |=> state_r == ldcs_pkg::LDCS_IDLE)
    else $error("apply lasted more than one cycle");

  cov_status_read: cover property (apply_stat);
  cov_cfg_read:    cover property (apply_cfg);
  cov_cfg_write:   cover property (apply_wr ##1 red_current_range_sel);
  cov_thermal:     cover property (status_r[215] && status_r[214]);

endmodule // ldcs_bank

/* logic/ldcs_pkg.sv */
package ldcs_pkg;

  // ****************************************************************
  // frame and register map
  // ****************************************************************
  localparam int          FRAME_W        = 288;
  localparam logic [1:0]  CFG_OFFSET     = 2'h1;
  localparam logic [1:0]  STATUS_OFFSET  = 2'h2;
  localparam int          CMD_HI         = 287;
  localparam int          CMD_LO         = 276;
  localparam int          CFG_KEEP_W     = 193;
  localparam int          CFG_RSV_W      = 83;
  localparam logic [11:0] CMD_READ_STAT  = 12'h5A3;
  localparam logic [11:0] CMD_READ_CFG   = 12'h5AC;
  localparam logic [11:0] CMD_RESET_VAL  = 12'h000;

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  localparam int POS_RANGE_R   = 192;
  localparam int BLUE_BR_LO    = 184;
  localparam int GREEN_BR_LO   = 176;
  localparam int RED_BR_LO     = 168;
  localparam int BR_W          = 8;
  localparam int TRIM_W        = 7;
  localparam int TRIM_ALL_W    = 168;
  localparam logic [CFG_KEEP_W-1:0] CFG_RESET_VAL = '0;

  // ****************************************************************
  // status fields
  // ****************************************************************
  localparam int OPEN2_LO      = 264;
  localparam int OPEN1_LO      = 240;
  localparam int APS_LO        = 216;
  localparam int POS_THERM     = 215;
  localparam int POS_WARN      = 214;
  localparam int PSR_LO        = 211;
  localparam int POS_REF_SHORT = 210;
  localparam int POS_REF_OPEN  = 209;
  localparam int STR_LO        = 206;
  localparam int SHORT2_LO     = 168;
  localparam int SHORT1_LO     = 144;
  localparam int GRP_W         = 24;
  localparam int CODE_W        = 3;
  localparam int STAT_RSV_HI_W = 14;
  localparam int STAT_RSV_LO_W = 144;
  localparam logic [FRAME_W-1:0] STATUS_RESET_VAL = '0;

  // ****************************************************************
  // frame handling states
  // ****************************************************************
  typedef enum logic [2:0] {
    LDCS_IDLE  = 3'b001,
    LDCS_SHIFT = 3'b010,
    LDCS_APPLY = 3'b100
  } ldcs_state_t;

endpackage

/* logic/ldcs_shift.sv */
`timescale 1ns/1ps
// frame shift register, msb first, with parallel load
module ldcs_shift #(
  parameter int W = 288
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // serial side
  input  wire logic         shift_en,
  input  wire logic         sdi_bit,
  output logic              sdo,
  // parallel side
  input  wire logic         load_en,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] data
);

  // load wins over a shift in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data <= '0;
    end else if (ce) begin
      if (load_en) begin
        data <= load_val;
      end else if (shift_en) begin
        data <= {data[W-2:0], sdi_bit};
      end
    end
  end

  assign sdo = data[W-1]; // straight from the frame flop

endmodule // ldcs_shift

/* logic/ldcs_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module ldcs_sync #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // ldcs_sync

/* test/ldcs_bank_tb_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the configuration and fault status bank
// ****************************************************************
module ldcs_bank_tb_top;
  // design pins
  logic          clk;
  logic          rst_n;
  logic          ce;
  logic          sclk_pin;
  logic          sdi_pin;
  logic          latch_pin;
  logic          sdo_pin;
  logic [23:0]   open_detect_level_two, open_detect_level_one, adjacent_pin_short;
  logic [23:0]   short_detect_level_two, short_detect_level_one;
  logic          thermal_error_flag, overtemp_warning, reference_short_fault, reference_open_fault;
  logic [2:0]    pin_short_test_result, open_short_selftest_result;
  logic          red_current_range_sel;
  logic [7:0]    blue_group_brightness, green_group_brightness, red_group_brightness;
  logic [167:0]  channel_current_trim;
  logic [287:0]  fault_status_word;
  logic [1:0]    loaded_offset;
  // bench state
  int            failures;
  int            n_compared;
  int            seed;
  logic [287:0]  f;
  logic [287:0]  a;
  logic [287:0]  got;
  logic [287:0]  st;
  logic [192:0]  cfg;

  ldcs_bank uut (.clk, .rst_n, .ce, .sclk_pin, .sdi_pin, .latch_pin, .sdo_pin,
    .open_detect_level_two, .open_detect_level_one, .adjacent_pin_short, .short_detect_level_two,
    .short_detect_level_one, .thermal_error_flag, .overtemp_warning, .pin_short_test_result,
    .reference_short_fault, .reference_open_fault, .open_short_selftest_result, .red_current_range_sel,
    .blue_group_brightness, .green_group_brightness, .red_group_brightness, .channel_current_trim,
    .fault_status_word, .loaded_offset);

  ldcs_host host (.clk, .sdo_pin, .sclk_pin, .sdi_pin, .latch_pin);

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [287:0] seen, input logic [287:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // status word built from the live detector levels
  function automatic logic [287:0] exp_status();
    return {open_detect_level_two, open_detect_level_one, adjacent_pin_short, thermal_error_flag,
            overtemp_warning, pin_short_test_result, reference_short_fault, reference_open_fault,
            open_short_selftest_result, 14'h0000, short_detect_level_two, short_detect_level_one, 144'h0};
  endfunction

  // any code other than the two reads is a write
  function automatic logic [11:0] write_cmd(input logic [11:0] c);
    return (c == 12'h5A3 || c == 12'h5AC) ? c ^ 12'h001 : c;
  endfunction

  task automatic rand_frame(output logic [287:0] r);
    r = '0;
    for (int w = 0; w < 9; w++)
      r = {r[255:0], 32'($random(seed))};
  endtask

  // mode 0 clears, 1 draws at random, 2 sets every flag
  task automatic set_detectors(input int mode, input logic [2:0] psr, input logic [2:0] str);
    logic [31:0] r;
    r = 32'($random(seed));
    open_detect_level_two      = (mode == 0) ? 24'h0 : (mode == 2) ? 24'hFFFFFF : 24'($random(seed));
    open_detect_level_one      = (mode == 0) ? 24'h0 : (mode == 2) ? 24'hFFFFFF : 24'($random(seed));
    adjacent_pin_short         = (mode == 0) ? 24'h0 : (mode == 2) ? 24'hFFFFFF : 24'($random(seed));
    short_detect_level_two     = (mode == 0) ? 24'h0 : (mode == 2) ? 24'hFFFFFF : 24'($random(seed));
    short_detect_level_one     = (mode == 0) ? 24'h0 : (mode == 2) ? 24'hFFFFFF : 24'($random(seed));
    {thermal_error_flag, overtemp_warning, reference_short_fault, reference_open_fault} =
      (mode == 0) ? 4'h0 : (mode == 2) ? 4'hF : r[3:0];
    pin_short_test_result      = psr;
    open_short_selftest_result = str;
  endtask

  task automatic check_cfg(input logic [192:0] c);
    check(red_current_range_sel, c[192], "range select");
    check({blue_group_brightness, green_group_brightness, red_group_brightness}, c[191:168], "bright");
    check(channel_current_trim, c[167:0], "trim");
  endtask

  task automatic check_status(input logic [287:0] s);
    check(fault_status_word[287:216], s[287:216], "channel flags");
    check(fault_status_word[215:206], s[215:206], "single flags");
    check(fault_status_word[205:0], s[205:0], "short flags");
  endtask

  // hold reset six cycles and look at every output while it is held
  task automatic reset_check();
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    check_cfg('0);
    check_status('0);
    check(loaded_offset, 2'h0, "offset");
    check(sdo_pin, 1'b0, "serial out");
    rst_n = 1'b1;
    $display("test reset finished");
  endtask

  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("[ERR] %0t run limit reached", $time);
    complete_run();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    failures   = 0;
    n_compared = 0;
    seed       = 32'h4209;
    ce         = 1'b1;
    set_detectors(0, 3'h0, 3'h0);
    reset_check();
    // configuration writes, all-ones and single-bit corners first
    for (int k = 0; k < 4; k++) begin
      rand_frame(f);
      if (k == 0) f = '1;
      if (k == 1) f = {95'h0, 1'h1, 192'h0};
      f[287:276] = write_cmd(f[287:276]);
      host.shift_frame(f, got);
      host.latch_frame();
      cfg = f[192:0];
      check_cfg(cfg);
      check_status('0);
    end
    $display("test config write finished");
    // configuration readback leaves the settings alone
    rand_frame(f);
    f[287:276] = 12'h5AC;
    host.shift_frame(f, got);
    host.latch_frame();
    check_cfg(cfg);
    check(loaded_offset, 2'h1, "offset");
    host.shift_frame(f, got);
    check(got[275:0], {83'h0, cfg}, "cfg readback");
    $display("test config read finished");
    // status flags and both result codes, the first two passes also read back on the serial chain
    for (int k = 0; k < 6; k++) begin
      set_detectors((k == 5) ? 2 : 1, (k % 2) ? 3'h3 : 3'h6, (k % 2) ? 3'h6 : 3'h3);
      repeat (4) @(posedge clk);
      #2;
      st = exp_status();
      check_status(st);
      if (k < 2) begin
        f = {12'h5A3, 276'h0};
        host.shift_frame(f, got);
        host.latch_frame();
        check(loaded_offset, 2'h2, "offset");
        host.shift_frame(f, got);
        check(got, st, "status readback");
      end
    end
    $display("test status finished");
    // two frames back to back: the first comes out while the second goes in
    rand_frame(a);
    a[287:276] = write_cmd(a[287:276]);
    rand_frame(f);
    f[287:276] = write_cmd(f[287:276]);
    host.shift_frame(a, got);
    host.shift_frame(f, got);
    check(got, a, "chain pass");
    host.latch_frame();
    check_cfg(f[192:0]);
    check_status(st);
    $display("test chain finished");
    // clock enable low freezes the status word
    ce = 1'b0;
    set_detectors(1, 3'h3, 3'h3);
    repeat (6) @(posedge clk);
    #2;
    check_status(st);
    ce = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    check_status(exp_status());
    $display("test freeze finished");
    reset_check();
    complete_run();
  end
endmodule // ldcs_bank_tb_top

/* test/ldcs_host.sv */
`timescale 1ns/1ps
// ****************************************************************
// host controller model driving the serial chain
// ****************************************************************
module ldcs_host #(
  parameter int PH = 4
) (
  // clock
  input  wire logic clk,
  // serial pins
  input  wire logic sdo_pin,
  output logic      sclk_pin,
  output logic      sdi_pin,
  output logic      latch_pin
);
  // serial clock stands still low outside frames
  initial begin
    sclk_pin  = 1'b0;
    sdi_pin   = 1'b0;
    latch_pin = 1'b0;
  end

  // shift one 288-bit frame msb first, capturing what the chain pushes out
  task automatic shift_frame(input logic [287:0] f, output logic [287:0] got);
    for (int i = ldcs_pkg::FRAME_W - 1; i >= 0; i--) begin
      sdi_pin = f[i];
      repeat (PH) @(posedge clk);
      #2;
      got[i]   = sdo_pin;   // msb still stands before the shift
      sclk_pin = 1'b1;
      repeat (PH) @(posedge clk);
      #2;
      sclk_pin = 1'b0;
    end
    sdi_pin = ~sdi_pin;     // released data line shows the inverse
    @(posedge clk);         // keeps the next frame's first bit off this time step
    #2;
  endtask

  // latch pulse, then wait for the apply cycle to land
  task automatic latch_frame();
    repeat (PH) @(posedge clk);
    #2;
    latch_pin = 1'b1;
    repeat (PH) @(posedge clk);
    #2;
    latch_pin = 1'b0;
    repeat (2 * PH) @(posedge clk);
    #2;
  endtask
endmodule // ldcs_host
